// ===== pdc_consts.vh
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
// register byte addresses
`define PDC_ADDR_STATUS 8'h00
`define PDC_ADDR_IRQ 8'h04
`define PDC_ADDR_MASK 8'h08
`define PDC_ADDR_CTRL 8'h0C
`define PDC_ADDR_RAW 8'h10
// status fields
`define PDC_ST_RUN 0
`define PDC_ST_STOP 1
`define PDC_ST_DIS 2
`define PDC_ST_CLR 3
`define PDC_ST_PHERR 4
`define PDC_ST_VERR 5
`define PDC_ST_UNUSED 6
// interrupt bits
`define PDC_IRQ_W 4
`define PDC_IRQ_STOP 0
`define PDC_IRQ_DIS 1
`define PDC_IRQ_CLR 2
`define PDC_IRQ_CFG 3
// ctrl
`define PDC_CTRL_SWCLR 0
// frequencies in Hz
`define PDC_F_50 8'h32
`define PDC_F_60 8'h3C
`define PDC_F_OVR 8'h05
`define PDC_F_MIN45 8'h2D
`define PDC_F_MIN40 8'h28
`define PDC_F_MIN30 8'h1E
`define PDC_F_MIN10 8'h0A
// voltage codes
`define PDC_V_115 2'h0
`define PDC_V_208 2'h1
`define PDC_V_230 2'h2
`define PDC_V_BAD 2'h3
// debounce time in us and cycles at 125 MHz
`define PDC_DB_US 5000
`define PDC_CLK_MHZ 125
`define PDC_DB_CYC (`PDC_DB_US * `PDC_CLK_MHZ)
`define PDC_DB_W 20
`define PDC_NIN 19
// positions of the contact inputs in the debounced vector
`define PDC_IN_LOOP 16
`define PDC_IN_MCLR 17
`define PDC_IN_DIS 18
`endif

// ===== pdc_debounce.v
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_debounce #(
   parameter [`PDC_DB_W-1:0] DB_CYC = `PDC_DB_CYC
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire din,
   output reg dout
);
   reg s1_q;
   reg s2_q;
   reg [`PDC_DB_W-1:0] cnt_q;
   // two-stage synchroniser then stable-count filter
   always @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         cnt_q <= {`PDC_DB_W{1'b0}};
         dout <= 1'b0;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         if (s2_q == dout) begin
            cnt_q <= {`PDC_DB_W{1'b0}};
         end else if (cnt_q >= DB_CYC - 1'b1) begin
            cnt_q <= {`PDC_DB_W{1'b0}};
            dout <= s2_q;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule

// ===== pdc_config_decoder.v
// How it works
// - open remote shutoff loop inhibits running and raises the stop indicator.
// - bank A has eight positions left to right, raised reads on.
// - bank A 1 and 2 pick phase; off/off single, on/on three; must match.
// - bank A 3 on selects 60 Hz, off selects 50 Hz nominal.
// - bank A 4 on allows up to 5 Hz over nominal, off caps at nominal.
// - bank A 5/6 set minimum: 45, 40, 30 or 10 Hz.
// - bank A 7/8 set voltage 230, 208, 115 VAC; on/off undefined.
// - bank B numbered top down, right is on; positions 2,3,4,7 unused, off.
// - bank B 1 ORed with external memory-clear switch as one clear request.
// - bank B 5 off narrow trip margin, on wide margin.
// - bank B 6 on suppresses motor-based overload and underload shutdowns.
// - system-based overload limits stay enforced regardless of bank B 6.
// - bank B 8 or external disable switch disables the system over everything.
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_config_decoder #(
   parameter [`PDC_DB_W-1:0] DB_CYC = `PDC_DB_CYC
) (
   input wire REF_CLK,
   input wire RST,
   input wire CE,
   input wire [7:0] CONFIG_BANK_A,
   input wire [7:0] CONFIG_BANK_B,
   input wire REMOTE_LOOP_CLOSED,
   input wire EXT_MEM_CLEAR,
   input wire EXT_DISABLE,
   input wire MOTOR_OVERLOAD,
   input wire MOTOR_UNDERLOAD,
   input wire SYS_OVERLOAD,
   output reg RUN_PERMIT,
   output reg STOP_IND,
   output reg SYSTEM_DISABLED,
   output reg THREE_PHASE,
   output reg PHASE_CFG_ERR,
   output reg [7:0] NOMINAL_FREQ,
   output reg [7:0] MAX_FREQ,
   output reg [7:0] MIN_FREQ,
   output reg [1:0] VOLT_SEL,
   output reg VOLT_CFG_ERR,
   output reg WIDE_MARGIN,
   output reg MOTOR_FAULT_EN,
   output reg FAULT_TRIP,
   output reg FAULT_CLEAR,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire HSEL,
   input wire HREADY,
   input wire [31:0] HWDATA,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   output reg IRQ
);
   wire [`PDC_NIN-1:0] raw_in;
   wire [`PDC_NIN-1:0] db_in;
   wire [7:0] bank_a;
   wire [7:0] bank_b;
   wire loop_closed;
   wire mem_clr_ext;
   wire dis_ext;
   reg [7:0] nom_d;
   reg [7:0] min_d;
   reg [1:0] volt_d;
   reg latched_fault_q;
   reg [`PDC_IRQ_W-1:0] irq_st_q;
   reg [`PDC_IRQ_W-1:0] irq_mask_q;
   reg [`PDC_IRQ_W-1:0] ev;
   reg sw_clr_q;
   reg prev_stop_q;
   reg prev_dis_q;
   reg prev_clr_q;
   reg prev_cfg_q;
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   wire clr_req;
   wire disabled;
   wire stop_now;
   wire mot_fault;
   wire cfg_bad;
   wire run_now;
   wire addr_ph;
   wire [31:0] status_word;
   integer i;

   // fault sense lines stay raw; only switches and field contacts are filtered
   assign raw_in = {EXT_DISABLE, EXT_MEM_CLEAR, REMOTE_LOOP_CLOSED, CONFIG_BANK_B,
                    CONFIG_BANK_A};

   // each input gets its own synchroniser and filter
   genvar g;
   generate
      for (g = 0; g < `PDC_NIN; g = g + 1) begin : deb
         pdc_debounce #(.DB_CYC(DB_CYC)) u_db (
            .clk(REF_CLK),
            .rst(RST),
            .ce(CE),
            .din(raw_in[g]),
            .dout(db_in[g])
         );
      end
   endgenerate

   // bit 0 is position 1 (leftmost / topmost); high reads on
   assign bank_a = db_in[7:0];
   assign bank_b = db_in[15:8];
   assign loop_closed = db_in[`PDC_IN_LOOP];
   assign mem_clr_ext = db_in[`PDC_IN_MCLR];
   assign dis_ext = db_in[`PDC_IN_DIS];

   assign clr_req = bank_b[0] | mem_clr_ext | sw_clr_q;
   assign disabled = bank_b[7] | dis_ext;
   assign stop_now = ~loop_closed;
   // motor-based trips only when bank B 6 is off; system trip always
   assign mot_fault = ~bank_b[5] & (MOTOR_OVERLOAD | MOTOR_UNDERLOAD);
   assign cfg_bad = phase_split(bank_a[1:0]) | (volt_of(bank_a[7:6]) == `PDC_V_BAD);
   assign run_now = ~disabled & ~stop_now & ~latched_fault_q & ~cfg_bad;

   // phase positions disagree
   function phase_split;
      input [1:0] p;
      begin
         phase_split = p[0] ^ p[1];
      end
   endfunction

   // nominal frequency from bank A position 3
   function [7:0] nom_of;
      input sel;
      begin
         nom_of = sel ? `PDC_F_60 : `PDC_F_50;
      end
   endfunction

   // ceiling, nominal plus overdrive when allowed
   function [7:0] max_of;
      input [7:0] nom;
      input ovr;
      begin
         max_of = ovr ? nom + `PDC_F_OVR : nom;
      end
   endfunction

   // minimum frequency, index is {position 6, position 5}
   function [7:0] min_of;
      input [1:0] sel;
      begin
         case (sel)
            2'b11: min_of = `PDC_F_MIN45;
            2'b10: min_of = `PDC_F_MIN40;
            2'b01: min_of = `PDC_F_MIN30;
            default: min_of = `PDC_F_MIN10;
         endcase
      end
   endfunction

   // voltage code, index is {position 8, position 7}
   function [1:0] volt_of;
      input [1:0] sel;
      begin
         case (sel)
            2'b11: volt_of = `PDC_V_230;
            2'b10: volt_of = `PDC_V_208;
            2'b00: volt_of = `PDC_V_115;
            default: volt_of = `PDC_V_BAD;
         endcase
      end
   endfunction

   always @* begin
      nom_d = nom_of(bank_a[2]);
      min_d = min_of(bank_a[5:4]);
      volt_d = volt_of(bank_a[7:6]);
   end

   always @* begin
      ev = {`PDC_IRQ_W{1'b0}};
      ev[`PDC_IRQ_STOP] = stop_now & ~prev_stop_q;
      ev[`PDC_IRQ_DIS] = disabled & ~prev_dis_q;
      ev[`PDC_IRQ_CLR] = (mot_fault | SYS_OVERLOAD) & ~latched_fault_q;
      ev[`PDC_IRQ_CFG] = cfg_bad & ~prev_cfg_q;
   end

   assign addr_ph = HSEL & HREADY & HTRANS[1];
   assign status_word = {25'h0, (bank_b[1] | bank_b[2] | bank_b[3] | bank_b[6]),
                         VOLT_CFG_ERR, PHASE_CFG_ERR, clr_req, SYSTEM_DISABLED,
                         STOP_IND, RUN_PERMIT};

   always @(posedge REF_CLK) begin
      if (RST) begin
         RUN_PERMIT <= 1'b0;
         STOP_IND <= 1'b1;
         SYSTEM_DISABLED <= 1'b0;
         THREE_PHASE <= 1'b0;
         PHASE_CFG_ERR <= 1'b0;
         NOMINAL_FREQ <= `PDC_F_50;
         MAX_FREQ <= `PDC_F_50;
         MIN_FREQ <= `PDC_F_MIN10;
         VOLT_SEL <= `PDC_V_115;
         VOLT_CFG_ERR <= 1'b0;
         WIDE_MARGIN <= 1'b0;
         MOTOR_FAULT_EN <= 1'b1;
         FAULT_TRIP <= 1'b0;
         FAULT_CLEAR <= 1'b0;
         latched_fault_q <= 1'b0;
         prev_stop_q <= 1'b1;
         prev_dis_q <= 1'b0;
         prev_clr_q <= 1'b0;
         prev_cfg_q <= 1'b0;
         IRQ <= 1'b0;
         irq_st_q <= {`PDC_IRQ_W{1'b0}};
      end else if (CE) begin
         STOP_IND <= stop_now;
         SYSTEM_DISABLED <= disabled;
         RUN_PERMIT <= run_now;
         THREE_PHASE <= bank_a[0] & bank_a[1];
         PHASE_CFG_ERR <= phase_split(bank_a[1:0]);
         NOMINAL_FREQ <= nom_d;
         MAX_FREQ <= max_of(nom_d, bank_a[3]);
         MIN_FREQ <= min_d;
         VOLT_SEL <= volt_d;
         VOLT_CFG_ERR <= volt_d == `PDC_V_BAD;
         WIDE_MARGIN <= bank_b[4];
         MOTOR_FAULT_EN <= ~bank_b[5];
         // system overload latches a trip whatever bank B 6 says
         if (mot_fault | SYS_OVERLOAD) begin
            latched_fault_q <= 1'b1;
         end else if (clr_req) begin
            latched_fault_q <= 1'b0;
         end
         FAULT_TRIP <= latched_fault_q | mot_fault | SYS_OVERLOAD;
         FAULT_CLEAR <= clr_req;
         prev_stop_q <= stop_now;
         prev_dis_q <= disabled;
         prev_clr_q <= clr_req;
         prev_cfg_q <= cfg_bad;
         // sticky status, set beats write-one clear
         for (i = 0; i < `PDC_IRQ_W; i = i + 1) begin
            if (ev[i]) begin
               irq_st_q[i] <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == `PDC_ADDR_IRQ && HWDATA[i]) begin
               irq_st_q[i] <= 1'b0;
            end
         end
         IRQ <= |(irq_st_q & irq_mask_q);
      end
   end

   // ahb-lite slave: zero wait states, always okay
   always @(posedge REF_CLK) begin
      if (RST) begin
         HRDATA <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         irq_mask_q <= {`PDC_IRQ_W{1'b0}};
         sw_clr_q <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (CE) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         // software clear is a one-cycle pulse
         sw_clr_q <= 1'b0;
         // ahb data phase write
         if (wr_pend_q) begin
            if (wr_addr_q == `PDC_ADDR_MASK) begin
               irq_mask_q <= HWDATA[`PDC_IRQ_W-1:0];
            end
            if (wr_addr_q == `PDC_ADDR_CTRL) begin
               sw_clr_q <= HWDATA[`PDC_CTRL_SWCLR];
            end
         end
         wr_pend_q <= addr_ph & HWRITE;
         if (addr_ph) begin
            wr_addr_q <= HADDR[7:0];
         end
         // zero-wait read data
         if (addr_ph & ~HWRITE) begin
            case (HADDR[7:0])
               `PDC_ADDR_STATUS: HRDATA <= status_word;
               `PDC_ADDR_IRQ: HRDATA <= {28'h0, irq_st_q};
               `PDC_ADDR_MASK: HRDATA <= {28'h0, irq_mask_q};
               `PDC_ADDR_CTRL: HRDATA <= 32'h0;
               `PDC_ADDR_RAW: HRDATA <= {16'h0, bank_b, bank_a};
               default: HRDATA <= 32'h0;
            endcase
         end else begin
            HRDATA <= 32'h0;
         end
      end
   end
endmodule

// ===== pdc_field.sv
`timescale 1ns/1ns
module pdc_field (
   input wire logic clk,
   output logic [7:0] bank_a,
   output logic [7:0] bank_b,
   output logic [5:0] cts
);
   // cts: {sys ovl, motor unl, motor ovl, ext disable, mem clear, loop closed}
   initial begin
      bank_a = 8'h00;
      bank_b = 8'h00;
      cts = 6'h01;
   end
   // new switch and contact levels land just after an edge
   task automatic put(input logic [7:0] a, input logic [7:0] b, input logic [5:0] c);
      @(posedge clk);
      bank_a <= a;
      bank_b <= b & 8'hB1;
      cts <= c;
   endtask
endmodule

// ===== pdc_config_decoder_chk.sv
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_config_chk (
   input wire REF_CLK,
   input wire RST,
   input wire [7:0] CONFIG_BANK_B,
   input wire REMOTE_LOOP_CLOSED,
   input wire EXT_DISABLE,
   input wire SYS_OVERLOAD,
   input wire RUN_PERMIT,
   input wire STOP_IND,
   input wire SYSTEM_DISABLED,
   input wire PHASE_CFG_ERR,
   input wire [7:0] NOMINAL_FREQ,
   input wire [7:0] MAX_FREQ,
   input wire FAULT_TRIP
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   property p_stop_run; STOP_IND |-> !RUN_PERMIT; endproperty
   a_stop_run: assert property (p_stop_run) else $error("run while stopped");
   property p_loop; !REMOTE_LOOP_CLOSED [*8] |=> ##1 STOP_IND; endproperty
   a_loop: assert property (p_loop) else $error("open loop without stop");
   property p_dis_run; SYSTEM_DISABLED |-> !RUN_PERMIT; endproperty
   a_dis_run: assert property (p_dis_run) else $error("run while disabled");
   property p_dis_deb;
      $rose(SYSTEM_DISABLED) |-> $past(EXT_DISABLE | CONFIG_BANK_B[7], 3)
         && $past(EXT_DISABLE | CONFIG_BANK_B[7], 5);
   endproperty
   a_dis_deb: assert property (p_dis_deb) else $error("disable not debounced");
   property p_phase; PHASE_CFG_ERR |-> !RUN_PERMIT; endproperty
   a_phase: assert property (p_phase) else $error("run with phase error");
   property p_nom; NOMINAL_FREQ == `PDC_F_50 || NOMINAL_FREQ == `PDC_F_60; endproperty
   a_nom: assert property (p_nom) else $error("bad nominal");
   property p_max;
      $stable(NOMINAL_FREQ) ##1 $stable(NOMINAL_FREQ)
         |-> MAX_FREQ == NOMINAL_FREQ || MAX_FREQ == NOMINAL_FREQ + `PDC_F_OVR;
   endproperty
   a_max: assert property (p_max) else $error("bad max");
   property p_sys; SYS_OVERLOAD |-> ##[1:3] FAULT_TRIP; endproperty
   a_sys: assert property (p_sys) else $error("system overload missed");
endmodule
bind pdc_config_decoder pdc_config_chk u_chk (.REF_CLK(REF_CLK), .RST(RST),
   .CONFIG_BANK_B(CONFIG_BANK_B), .REMOTE_LOOP_CLOSED(REMOTE_LOOP_CLOSED),
   .EXT_DISABLE(EXT_DISABLE), .SYS_OVERLOAD(SYS_OVERLOAD), .RUN_PERMIT(RUN_PERMIT),
   .STOP_IND(STOP_IND), .SYSTEM_DISABLED(SYSTEM_DISABLED), .PHASE_CFG_ERR(PHASE_CFG_ERR),
   .NOMINAL_FREQ(NOMINAL_FREQ), .MAX_FREQ(MAX_FREQ), .FAULT_TRIP(FAULT_TRIP));

// ===== tb_pdc_config_decoder.sv
`timescale 1ns/1ns
`include "pdc_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_pdc_config_decoder;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] rd;
   int n_errors = 0;
   int tests_run = 0;
   wire [7:0] ba, bb, NOMINAL_FREQ, MAX_FREQ, MIN_FREQ;
   wire [5:0] ct;
   wire [1:0] VOLT_SEL;
   wire [31:0] HRDATA;
   wire RUN_PERMIT, STOP_IND, SYSTEM_DISABLED, THREE_PHASE, PHASE_CFG_ERR, VOLT_CFG_ERR;
   wire WIDE_MARGIN, MOTOR_FAULT_EN, FAULT_TRIP, HREADYOUT, IRQ, FAULT_CLEAR, HRESP;
   logic [7:0] mn [4] = '{`PDC_F_MIN10, `PDC_F_MIN30, `PDC_F_MIN40, `PDC_F_MIN45};
   logic [1:0] vt [4] = '{`PDC_V_115, `PDC_V_BAD, `PDC_V_208, `PDC_V_230};
   pdc_field fld (.clk(REF_CLK), .bank_a(ba), .bank_b(bb), .cts(ct));
   pdc_config_decoder #(.DB_CYC(20'h00004)) dut (.REF_CLK(REF_CLK), .RST(RST), .CE(1'b1),
      .CONFIG_BANK_A(ba), .CONFIG_BANK_B(bb), .REMOTE_LOOP_CLOSED(ct[0]),
      .EXT_MEM_CLEAR(ct[1]), .EXT_DISABLE(ct[2]), .MOTOR_OVERLOAD(ct[3]),
      .MOTOR_UNDERLOAD(ct[4]), .SYS_OVERLOAD(ct[5]), .RUN_PERMIT(RUN_PERMIT),
      .STOP_IND(STOP_IND), .SYSTEM_DISABLED(SYSTEM_DISABLED), .THREE_PHASE(THREE_PHASE),
      .PHASE_CFG_ERR(PHASE_CFG_ERR), .NOMINAL_FREQ(NOMINAL_FREQ), .MAX_FREQ(MAX_FREQ),
      .MIN_FREQ(MIN_FREQ), .VOLT_SEL(VOLT_SEL), .VOLT_CFG_ERR(VOLT_CFG_ERR),
      .WIDE_MARGIN(WIDE_MARGIN), .MOTOR_FAULT_EN(MOTOR_FAULT_EN), .FAULT_TRIP(FAULT_TRIP),
      .FAULT_CLEAR(FAULT_CLEAR), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(3'h2),
      .HSEL(1'b1), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));
   always #4 REF_CLK = ~REF_CLK;
   task automatic cyc(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask
   // set switches, then wait out sync and debounce
   task automatic st(input logic [7:0] a, input logic [7:0] b, input logic [5:0] c);
      fld.put(a, b, c);
      cyc(12);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HADDR <= {24'h0, a};
      HTRANS <= 2'h2;
      HWRITE <= w;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic t_cfg;
      logic [1:0] k;
      logic [7:0] nf;
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         nf = k[0] ? `PDC_F_60 : `PDC_F_50;
         st({k, k, k[1], k[0], {2{k[0]}}}, {2'h0, k, 4'h0}, 6'h01);
         `CHK(THREE_PHASE, k[0])
         `CHK(NOMINAL_FREQ, nf)
         `CHK(MAX_FREQ, nf + (k[1] ? `PDC_F_OVR : 8'h00))
         `CHK(MIN_FREQ, mn[i])
         `CHK(VOLT_SEL, vt[i])
         `CHK(VOLT_CFG_ERR, k == 2'h1)
         `CHK(RUN_PERMIT, k != 2'h1)
         `CHK(WIDE_MARGIN, k[0])
         `CHK(MOTOR_FAULT_EN, !k[1])
      end
      st(8'h01, 8'h00, 6'h01);
      `CHK(PHASE_CFG_ERR, 1'b1)
      `CHK(RUN_PERMIT, 1'b0)
   endtask
   task automatic t_irq;
      bus(1'b1, `PDC_ADDR_MASK, 32'h0);
      bus(1'b1, `PDC_ADDR_IRQ, 32'hF);
      st(8'h00, 8'h00, 6'h00);
      `CHK(STOP_IND, 1'b1)
      `CHK(RUN_PERMIT, 1'b0)
      `CHK(IRQ, 1'b0)
      bus(1'b1, `PDC_ADDR_MASK, 32'h1);
      cyc(3);
      `CHK(IRQ, 1'b1)
      bus(1'b0, `PDC_ADDR_IRQ, 32'h0);
      `CHK(rd[0], 1'b1)
      bus(1'b1, `PDC_ADDR_IRQ, 32'h1);
      cyc(3);
      `CHK(IRQ, 1'b0)
      bus(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(HRESP, 1'b0)
      st(8'h00, 8'h00, 6'h01);
      `CHK(RUN_PERMIT, 1'b1)
   endtask
   task automatic t_dis;
      fld.put(8'h00, 8'h00, 6'h05);
      st(8'h00, 8'h00, 6'h01);
      `CHK(SYSTEM_DISABLED, 1'b0)
      for (int s = 0; s < 2; s++) begin
         st(8'h00, s ? 8'h80 : 8'h00, s ? 6'h01 : 6'h05);
         `CHK(SYSTEM_DISABLED, 1'b1)
         `CHK(RUN_PERMIT, 1'b0)
         st(8'h00, 8'h00, 6'h01);
      end
   endtask
   task automatic t_flt;
      st(8'h00, 8'h20, 6'h01);
      fld.put(8'h00, 8'h20, 6'h19);
      st(8'h00, 8'h20, 6'h01);
      `CHK(FAULT_TRIP, 1'b0)
      fld.put(8'h00, 8'h20, 6'h21);
      st(8'h00, 8'h20, 6'h01);
      `CHK(FAULT_TRIP, 1'b1)
      st(8'h00, 8'h20, 6'h03);
      `CHK(FAULT_TRIP, 1'b0)
      `CHK(FAULT_CLEAR, 1'b1)
      st(8'h00, 8'h00, 6'h01);
      `CHK(FAULT_CLEAR, 1'b0)
      fld.put(8'h00, 8'h00, 6'h11);
      st(8'h00, 8'h00, 6'h01);
      `CHK(FAULT_TRIP, 1'b1)
      st(8'h00, 8'h01, 6'h01);
      `CHK(FAULT_TRIP, 1'b0)
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      cyc(3);
      RST <= 1'b0;
      cyc(12);
      t_cfg;
      t_irq;
      t_dis;
      t_flt;
      wrap_up;
   end
   initial begin
      #50000;
      n_errors++;
      wrap_up;
   end
endmodule
